// file: inc/pause_flow_consts.vh
/*
  Constants shared by the pause flow-control port: channel counts, field widths,
  and the values that the receive checks compare against.
  Assumes inclusion by bare name from the rtl files; definitions only.
*/
`ifndef PAUSE_FLOW_CONSTS_VH
`define PAUSE_FLOW_CONSTS_VH

// channel layout: priorities 0-7 plus the global channel
`define PFC_NCH 9
`define PFC_NPRIO 8
`define PFC_GLOBAL_CH 4'h8
`define PFC_CHW 4
`define PFC_QW 16
`define PFC_ADDRW 48

// fields of a received control frame
`define PFC_ETYPE_PAUSE 16'h8808
`define PFC_OP_GLOBAL 16'h0001
`define PFC_OP_PRIO 16'h0101
`define PFC_MCAST_DA 48'h0180_c200_0001
`define PFC_GROUP_BIT 40

// reset and compare values
`define PFC_CH_NONE 9'h000
`define PFC_GLOBAL_HIT 9'h100
`define PFC_Q_ZERO 16'h0000
`define PFC_Q_ONE 16'h0001
`define PFC_CH_ZERO 4'h0

`endif

// file: rtl/pause_rx_filter.v
/*
  Combinational acceptance filter for received pause frames.
  Assumes the frame fields are stable while frame_valid is high, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pause_flow_consts.vh"

module pause_rx_filter (
  // check enables
  input wire prio_enable,
  input wire check_mcast,
  input wire check_ucast,
  input wire check_sa,
  input wire check_etype,
  input wire check_opcode,
  input wire [`PFC_ADDRW-1:0] station_addr,
  // parsed frame
  input wire frame_valid,
  input wire [`PFC_ADDRW-1:0] dest_addr,
  input wire [`PFC_ADDRW-1:0] src_addr,
  input wire [`PFC_QW-1:0] ethertype,
  input wire [`PFC_QW-1:0] opcode,
  input wire [`PFC_NPRIO-1:0] class_vector,
  // channels hit by an accepted frame
  output reg [`PFC_NCH-1:0] hit
);

  wire is_global = (opcode == `PFC_OP_GLOBAL);
  wire da_mcast = (dest_addr == `PFC_MCAST_DA);
  wire da_ucast = (dest_addr == station_addr);
  // with neither address check on, any destination passes
  wire da_ok = ~(check_mcast | check_ucast) |
    (check_mcast & da_mcast) |
    (check_ucast & da_ucast);
  wire sa_ok = ~check_sa | ~src_addr[`PFC_GROUP_BIT];
  wire et_match = (ethertype == `PFC_ETYPE_PAUSE);
  wire et_ok = ~check_etype | et_match;
  wire op_ok = ~check_opcode | (opcode == `PFC_OP_PRIO);

  // global frames keep fixed checks; priority frames obey the enables
  always @* begin
    hit = `PFC_CH_NONE;
    if (frame_valid) begin
      if (is_global) begin
        if (et_match & (da_mcast | da_ucast))
          hit = `PFC_GLOBAL_HIT;
      end else if (prio_enable & da_ok & sa_ok & et_ok & op_ok) begin
        hit = {1'b0, class_vector};
      end
    end
  end

endmodule // pause_rx_filter
`default_nettype wire

// file: rtl/pause_tx_sched.v
/*
  Transmit pause scheduler: per-channel pending bits, resend timers, and one
  frame request at a time toward the transmit path.
  Assumes requests come from logic on the same clock and hold 16 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pause_flow_consts.vh"

module pause_tx_sched (
  // clock and reset
  input wire clk,
  input wire reset,
  // user requests
  input wire [`PFC_NCH-1:0] req,
  input wire [`PFC_NCH-1:0] en,
  input wire [`PFC_NCH*`PFC_QW-1:0] quanta_flat,
  input wire [`PFC_NCH*`PFC_QW-1:0] interval_flat,
  // frame request toward the transmit path
  input wire frame_ready,
  output reg frame_valid,
  output reg frame_global,
  output reg [`PFC_CHW-1:0] frame_chan,
  output reg [`PFC_QW-1:0] frame_quanta
);

  // lowest pending channel wins
  function [`PFC_CHW-1:0] first_set;
    input [`PFC_NCH-1:0] vec;
    integer k;
    begin
      first_set = `PFC_CH_ZERO;
      for (k = `PFC_NCH - 1; k >= 0; k = k - 1)
        if (vec[k])
          first_set = k[`PFC_CHW-1:0];
    end
  endfunction

  reg [`PFC_NCH-1:0] req_d;
  reg [`PFC_NCH-1:0] pend;
  reg [`PFC_NCH-1:0] armed;
  reg [`PFC_QW-1:0] timer [0:`PFC_NCH-1];
  reg [`PFC_NCH-1:0] done;
  reg [`PFC_NCH-1:0] fire;
  reg [`PFC_NCH-1:0] next_pend;
  wire sent = frame_valid & frame_ready;
  wire [`PFC_CHW-1:0] pick = first_set(pend);
  integer i;
  integer j; // clocked loops only, so no index has two writing processes

  // new edge or expired timer sets pending; a set beats the send clear
  always @* begin
    for (i = 0; i < `PFC_NCH; i = i + 1) begin
      done[i] = sent && (frame_chan == i);
      fire[i] = armed[i] & req[i] & (timer[i] == `PFC_Q_ONE);
      next_pend[i] = ((pend[i] & ~done[i]) | (req[i] & ~req_d[i]) | fire[i])
        & en[i];
    end
  end

  // pending bits and resend timers
  always @(posedge clk) begin
    if (reset) begin
      req_d <= `PFC_CH_NONE;
      pend <= `PFC_CH_NONE;
      armed <= `PFC_CH_NONE;
      for (j = 0; j < `PFC_NCH; j = j + 1)
        timer[j] <= `PFC_Q_ZERO;
    end else begin
      req_d <= req;
      pend <= next_pend;
      for (j = 0; j < `PFC_NCH; j = j + 1) begin
        if (done[j]) begin
          // zero interval means send once, no refresh
          timer[j] <= interval_flat[`PFC_QW*j +: `PFC_QW];
          armed[j] <= (interval_flat[`PFC_QW*j +: `PFC_QW] != `PFC_Q_ZERO);
        end else begin
          if (timer[j] != `PFC_Q_ZERO)
            timer[j] <= timer[j] - `PFC_Q_ONE;
          if (~req[j])
            armed[j] <= 1'b0;
        end
      end
    end
  end

  // frame request held until the transmit path takes it
  always @(posedge clk) begin
    if (reset) begin
      frame_valid <= 1'b0;
      frame_global <= 1'b0;
      frame_chan <= `PFC_CH_ZERO;
      frame_quanta <= `PFC_Q_ZERO;
    end else if (sent) begin
      frame_valid <= 1'b0;
    end else if (~frame_valid && (pend != `PFC_CH_NONE)) begin
      frame_valid <= 1'b1;
      frame_chan <= pick;
      frame_global <= (pick == `PFC_GLOBAL_CH);
      frame_quanta <= quanta_flat[`PFC_QW*pick +: `PFC_QW];
    end
  end

endmodule // pause_tx_sched
`default_nettype wire

// file: rtl/pause_flow_control_port.v
/*
  Pause flow-control port of a 100G Ethernet MAC: receive pause filtering and
  user signalling, transmit pause request scheduling.
  Assumes a parsed control frame from the receive path and a transmit path
  that takes one pause frame request at a time, all on clk.
*/
// Notes on behaviour
// - multicast destination check on priority pause frames when enabled
// - unicast destination check on priority pause frames when enabled
// - source address check on priority pause frames when enabled
// - Ethertype check on priority pause frames when enabled
// - opcode check on priority pause frames when enabled
// - accepted frame sets request bit, held until processed
// - valid bit per channel marks that channel's quanta as usable
// - a global pause frame sets valid bit 8
// - sixteen-bit quanta per priority; global quanta on channel 8
// - transmit request bit sends a pause frame with that channel's quanta
// - bit 8 sends a global frame, bits 0-7 priority frames
// - priority frames processed only under the priority enable
// - receive enable gates user signalling only, not internal tracking
// - transmit enable bit gates sending for its channel
// - per-channel refresh interval resends a pending pause frame
`timescale 1ns/1ps
`default_nettype none
`include "pause_flow_consts.vh"

module pause_flow_control_port (
  // clock and reset
  input wire clk,
  input wire reset,
  // receive check enables
  input wire prio_pause_enable,
  input wire prio_pause_check_mcast,
  input wire prio_pause_check_unicast,
  input wire prio_pause_check_source_addr,
  input wire prio_pause_check_ethertype,
  input wire prio_pause_check_opcode,
  input wire [`PFC_ADDRW-1:0] station_addr,
  input wire [`PFC_NCH-1:0] rx_pause_enable,
  // parsed control frame from the receive path
  input wire rx_ctl_frame_valid,
  input wire [`PFC_ADDRW-1:0] rx_ctl_dest_addr,
  input wire [`PFC_ADDRW-1:0] rx_ctl_src_addr,
  input wire [`PFC_QW-1:0] rx_ctl_ethertype,
  input wire [`PFC_QW-1:0] rx_ctl_opcode,
  input wire [`PFC_NPRIO-1:0] rx_ctl_class_vector,
  input wire [`PFC_NPRIO*`PFC_QW-1:0] rx_ctl_times,
  // receive user signalling
  output reg [`PFC_NCH-1:0] rx_flow_stop_req,
  input wire [`PFC_NCH-1:0] rx_flow_stop_ack,
  output reg [`PFC_NCH-1:0] rx_flow_stop_valid,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch0,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch1,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch2,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch3,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch4,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch5,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch6,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_ch7,
  output wire [`PFC_QW-1:0] rx_flow_stop_quanta_global,
  // transmit user requests
  input wire [`PFC_NCH-1:0] tx_flow_stop_req,
  input wire [`PFC_NCH-1:0] tx_pause_enable,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch0,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch1,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch2,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch3,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch4,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch5,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch6,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_ch7,
  input wire [`PFC_QW-1:0] tx_flow_stop_quanta_global,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch0,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch1,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch2,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch3,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch4,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch5,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch6,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_ch7,
  input wire [`PFC_QW-1:0] tx_flow_stop_resend_interval_global,
  // pause frame request toward the transmit path
  input wire tx_frame_ready,
  output wire tx_frame_valid,
  output wire tx_frame_global,
  output wire [`PFC_CHW-1:0] tx_frame_chan,
  output wire [`PFC_QW-1:0] tx_frame_quanta
);

  ////////////////////////////////////////////////////////////////////////////
  // receive filtering

  wire [`PFC_NCH-1:0] rx_hit;

  pause_rx_filter u_rx_filter (
    .prio_enable(prio_pause_enable),
    .check_mcast(prio_pause_check_mcast),
    .check_ucast(prio_pause_check_unicast),
    .check_sa(prio_pause_check_source_addr),
    .check_etype(prio_pause_check_ethertype),
    .check_opcode(prio_pause_check_opcode),
    .station_addr(station_addr),
    .frame_valid(rx_ctl_frame_valid),
    .dest_addr(rx_ctl_dest_addr),
    .src_addr(rx_ctl_src_addr),
    .ethertype(rx_ctl_ethertype),
    .opcode(rx_ctl_opcode),
    .class_vector(rx_ctl_class_vector),
    .hit(rx_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive request tracking

  // internal pending state runs whatever the per-channel enable says
  reg [`PFC_NCH-1:0] rx_pend;
  reg [`PFC_NCH-1:0] next_rx_pend;
  reg [`PFC_QW-1:0] rx_q [0:`PFC_NCH-1];
  integer i;

  // ack clears, but a frame landing on the same cycle keeps the bit set
  always @* begin
    next_rx_pend = (rx_pend & ~rx_flow_stop_ack) | rx_hit;
  end

  // pending bits and user-facing request and valid
  always @(posedge clk) begin
    if (reset) begin
      rx_pend <= `PFC_CH_NONE;
      rx_flow_stop_req <= `PFC_CH_NONE;
      rx_flow_stop_valid <= `PFC_CH_NONE;
    end else begin
      rx_pend <= next_rx_pend;
      // gating only here keeps disabled channels tracked internally
      rx_flow_stop_req <= next_rx_pend & rx_pause_enable;
      rx_flow_stop_valid <= rx_hit & rx_pause_enable;
    end
  end

  // quanta captured per channel; global frame carries its time in slot 0
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < `PFC_NCH; i = i + 1)
        rx_q[i] <= `PFC_Q_ZERO;
    end else begin
      for (i = 0; i < `PFC_NPRIO; i = i + 1)
        if (rx_hit[i] & rx_pause_enable[i])
          rx_q[i] <= rx_ctl_times[`PFC_QW*i +: `PFC_QW];
      if (rx_hit[`PFC_GLOBAL_CH] & rx_pause_enable[`PFC_GLOBAL_CH])
        rx_q[`PFC_GLOBAL_CH] <= rx_ctl_times[`PFC_QW-1:0];
    end
  end

  // quanta outputs read straight off the capture registers
  assign rx_flow_stop_quanta_ch0 = rx_q[0];
  assign rx_flow_stop_quanta_ch1 = rx_q[1];
  assign rx_flow_stop_quanta_ch2 = rx_q[2];
  assign rx_flow_stop_quanta_ch3 = rx_q[3];
  assign rx_flow_stop_quanta_ch4 = rx_q[4];
  assign rx_flow_stop_quanta_ch5 = rx_q[5];
  assign rx_flow_stop_quanta_ch6 = rx_q[6];
  assign rx_flow_stop_quanta_ch7 = rx_q[7];
  assign rx_flow_stop_quanta_global = rx_q[`PFC_GLOBAL_CH];

  ////////////////////////////////////////////////////////////////////////////
  // transmit scheduling

  // global channel sits at the top slot of each packed bus
  wire [`PFC_NCH*`PFC_QW-1:0] tx_q_flat = {
    tx_flow_stop_quanta_global, tx_flow_stop_quanta_ch7,
    tx_flow_stop_quanta_ch6, tx_flow_stop_quanta_ch5,
    tx_flow_stop_quanta_ch4, tx_flow_stop_quanta_ch3,
    tx_flow_stop_quanta_ch2, tx_flow_stop_quanta_ch1,
    tx_flow_stop_quanta_ch0};
  wire [`PFC_NCH*`PFC_QW-1:0] tx_iv_flat = {
    tx_flow_stop_resend_interval_global, tx_flow_stop_resend_interval_ch7,
    tx_flow_stop_resend_interval_ch6, tx_flow_stop_resend_interval_ch5,
    tx_flow_stop_resend_interval_ch4, tx_flow_stop_resend_interval_ch3,
    tx_flow_stop_resend_interval_ch2, tx_flow_stop_resend_interval_ch1,
    tx_flow_stop_resend_interval_ch0};

  // request edges are trusted as clean because the user holds them 16 cycles
  pause_tx_sched u_tx_sched (
    .clk(clk),
    .reset(reset),
    .req(tx_flow_stop_req),
    .en(tx_pause_enable),
    .quanta_flat(tx_q_flat),
    .interval_flat(tx_iv_flat),
    .frame_ready(tx_frame_ready),
    .frame_valid(tx_frame_valid),
    .frame_global(tx_frame_global),
    .frame_chan(tx_frame_chan),
    .frame_quanta(tx_frame_quanta)
  );

endmodule // pause_flow_control_port
`default_nettype wire

// file: testbench/pause_flow_properties.sv
/* Pin-level assertions for the pause flow-control port.
   Assumes a bind onto pause_flow_control_port, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module pause_flow_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // receive side
  input wire logic prio_pause_enable,
  input wire logic [8:0] rx_pause_enable,
  input wire logic rx_ctl_frame_valid,
  input wire logic [15:0] rx_ctl_opcode,
  input wire logic [8:0] rx_flow_stop_req,
  input wire logic [8:0] rx_flow_stop_ack,
  input wire logic [8:0] rx_flow_stop_valid,
  // transmit side
  input wire logic tx_frame_ready,
  input wire logic tx_frame_valid,
  input wire logic tx_frame_global,
  input wire logic [3:0] tx_frame_chan,
  input wire logic [15:0] tx_frame_quanta
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // transmit handshake steps
  sequence s_waiting;
    tx_frame_valid && !tx_frame_ready;
  endsequence
  sequence s_taken;
    tx_frame_valid && tx_frame_ready;
  endsequence
  ////////////////////////////////////////
  a_valid_needs_frame: assert property (
    rx_flow_stop_valid != 9'h000 |-> $past(rx_ctl_frame_valid)) else $error("valid without frame");
  a_req_held: assert property (
    ($past(rx_flow_stop_req) & ~rx_flow_stop_req & ~$past(rx_flow_stop_ack)
      & $past(rx_pause_enable) & rx_pause_enable) == 9'h000) else $error("req fell without ack");
  a_ack_clears: assert property (
    !$past(rx_ctl_frame_valid) |-> ($past(rx_flow_stop_ack) & $past(rx_flow_stop_req)
      & rx_flow_stop_req) == 9'h000) else $error("req kept after ack");
  a_prio_gated: assert property (
    rx_ctl_frame_valid && !prio_pause_enable && rx_ctl_opcode != 16'h0001
      |=> rx_flow_stop_valid == 9'h000) else $error("priority frame taken while disabled");
  a_rx_en_gate: assert property (
    (rx_flow_stop_valid & ~$past(rx_pause_enable)) == 9'h000) else $error("valid on gated channel");
  a_tx_hold: assert property (
    s_waiting |=> tx_frame_valid && $stable(tx_frame_chan) && $stable(tx_frame_quanta)
      && $stable(tx_frame_global)) else $error("frame request changed before ready");
  a_tx_gap: assert property (
    s_taken |=> !tx_frame_valid) else $error("no idle cycle after frame");
  a_tx_global: assert property (
    tx_frame_valid |-> tx_frame_global == (tx_frame_chan == 4'h8)) else $error("global flag wrong");
endmodule // pause_flow_checker
bind pause_flow_control_port pause_flow_checker props (
  .clk, .reset, .prio_pause_enable, .rx_pause_enable, .rx_ctl_frame_valid, .rx_ctl_opcode,
  .rx_flow_stop_req, .rx_flow_stop_ack, .rx_flow_stop_valid, .tx_frame_ready,
  .tx_frame_valid, .tx_frame_global, .tx_frame_chan, .tx_frame_quanta
);
`default_nettype wire

// file: testbench/flow_user_model.sv
/* Far-side user logic: acknowledges receive pause requests, accepts pause
   frame requests. Assumes the port's clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module flow_user_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pace: when 1, answers only every fourth cycle
  input wire logic slow,
  // receive requests and acknowledges
  input wire logic [8:0] req,
  output logic [8:0] ack,
  // transmit path acceptance
  output logic ready
);
  logic [1:0] age;
  logic go;
  assign go = ~slow | (age == 2'h3);
  // one-cycle ack per seen request, so a stuck req shows up as a second ack
  always @(posedge clk) begin
    if (reset) begin
      ack <= 9'h000;
      ready <= 1'b0;
      age <= 2'h0;
    end else begin
      age <= age + 2'h1;
      ack <= go ? (req & ~ack) : 9'h000;
      ready <= go;
    end
  end
endmodule // flow_user_model
`default_nettype wire

// file: testbench/tb.sv
/* Self-checking bench for the pause flow-control port.
   Assumes the user model and the bound checker; 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`include "pause_flow_consts.vh"
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic en_prio, ck_m, ck_u, ck_s, ck_e, ck_o, fv, slow, seen;
  logic [47:0] sta, da, sa, bd, bs;
  logic [15:0] et, op, ivl, be, bo;
  logic [7:0] cv;
  logic [127:0] tv;
  logic [8:0] rxen, txen, txr;
  logic [15:0] txq [0:8];
  wire [15:0] rxq [0:8];
  wire [8:0] rq, rv, ack;
  wire tvld, tg, rdy;
  wire [3:0] tch;
  wire [15:0] tq;
  int fail_count = 0;
  int comparisons = 0;
  int k;
  // free-running clock
  always #5 clk = ~clk;
  pause_flow_control_port dut (
    .clk(clk), .reset(reset), .prio_pause_enable(en_prio), .prio_pause_check_mcast(ck_m),
    .prio_pause_check_unicast(ck_u), .prio_pause_check_source_addr(ck_s),
    .prio_pause_check_ethertype(ck_e), .prio_pause_check_opcode(ck_o), .station_addr(sta),
    .rx_pause_enable(rxen), .rx_ctl_frame_valid(fv), .rx_ctl_dest_addr(da),
    .rx_ctl_src_addr(sa), .rx_ctl_ethertype(et), .rx_ctl_opcode(op),
    .rx_ctl_class_vector(cv), .rx_ctl_times(tv), .rx_flow_stop_req(rq),
    .rx_flow_stop_ack(ack), .rx_flow_stop_valid(rv),
    .rx_flow_stop_quanta_ch0(rxq[0]), .rx_flow_stop_quanta_ch1(rxq[1]),
    .rx_flow_stop_quanta_ch2(rxq[2]), .rx_flow_stop_quanta_ch3(rxq[3]),
    .rx_flow_stop_quanta_ch4(rxq[4]), .rx_flow_stop_quanta_ch5(rxq[5]),
    .rx_flow_stop_quanta_ch6(rxq[6]), .rx_flow_stop_quanta_ch7(rxq[7]),
    .rx_flow_stop_quanta_global(rxq[8]), .tx_flow_stop_req(txr), .tx_pause_enable(txen),
    .tx_flow_stop_quanta_ch0(txq[0]), .tx_flow_stop_quanta_ch1(txq[1]),
    .tx_flow_stop_quanta_ch2(txq[2]), .tx_flow_stop_quanta_ch3(txq[3]),
    .tx_flow_stop_quanta_ch4(txq[4]), .tx_flow_stop_quanta_ch5(txq[5]),
    .tx_flow_stop_quanta_ch6(txq[6]), .tx_flow_stop_quanta_ch7(txq[7]),
    .tx_flow_stop_quanta_global(txq[8]), .tx_flow_stop_resend_interval_ch0(ivl),
    .tx_flow_stop_resend_interval_ch1(ivl), .tx_flow_stop_resend_interval_ch2(ivl),
    .tx_flow_stop_resend_interval_ch3(ivl), .tx_flow_stop_resend_interval_ch4(ivl),
    .tx_flow_stop_resend_interval_ch5(ivl), .tx_flow_stop_resend_interval_ch6(ivl),
    .tx_flow_stop_resend_interval_ch7(ivl), .tx_flow_stop_resend_interval_global(ivl),
    .tx_frame_ready(rdy), .tx_frame_valid(tvld), .tx_frame_global(tg),
    .tx_frame_chan(tch), .tx_frame_quanta(tq)
  );
  flow_user_model user (.clk(clk), .reset(reset), .slow(slow), .req(rq), .ack(ack), .ready(rdy));
  ////////////////////////////////////////
  task give_verdict;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [15:0] g, x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle parsed frame, outputs settled on return
  task frame(input logic [47:0] d, s, input logic [15:0] e, o, input logic [7:0] c);
    @(posedge clk);
    fv <= 1'b1;
    da <= d;
    sa <= s;
    et <= e;
    op <= o;
    cv <= c;
    @(posedge clk);
    fv <= 1'b0;
    #1;
  endtask
  // bounded wait: a hang becomes a mismatch, not a stuck run
  task wait_lvl(input logic want);
    int n;
    n = 0;
    while (tvld !== want) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        fail_count++;
        give_verdict();
      end
    end
  endtask
  task wait_tx(input logic [3:0] c, input logic g, input logic [15:0] q);
    wait_lvl(1'b1);
    chk(tch, c);
    chk(tg, g);
    chk(tq, q);
    wait_lvl(1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    {en_prio, ck_m, ck_u, ck_s, ck_e, ck_o} = 6'h3f;
    {fv, slow, da, sa, et, op, cv, txr} = '0;
    sta = 48'h0200_0000_0042;
    ivl = 16'h0014;
    rxen = 9'h1ff;
    txen = 9'h1fb;
    tv = 128'h1007_1006_1005_1004_1003_1002_1001_1000;
    for (k = 0; k < 9; k++) txq[k] = 16'h0a00 + 16'(k);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    frame(`PFC_MCAST_DA, 48'h0, `PFC_ETYPE_PAUSE, `PFC_OP_PRIO, 8'h05);
    chk(rv, 9'h005);
    chk(rq, 9'h005);
    chk(rxq[0], tv[15:0]);
    chk(rxq[2], tv[47:32]);
    look(4);
    chk(rq, 9'h000);
    @(posedge clk);
    slow <= 1'b1;
    frame(sta, 48'h0, `PFC_ETYPE_PAUSE, `PFC_OP_GLOBAL, 8'h00);
    chk(rv, 9'h100);
    chk(rxq[8], tv[15:0]);
    look(1);
    chk(rq, 9'h100);
    look(8);
    chk(rq, 9'h000);
    // each check alone rejects its bad field; with checks off it passes
    for (k = 0; k < 5; k++) begin
      bd = (k == 1) ? `PFC_MCAST_DA : sta;
      bs = (k == 2) ? 48'h0100_0000_0000 : 48'h0;
      be = (k == 3) ? 16'h1234 : `PFC_ETYPE_PAUSE;
      bo = (k == 4) ? 16'h0202 : `PFC_OP_PRIO;
      @(posedge clk);
      {ck_m, ck_u, ck_s, ck_e, ck_o} <= 5'(5'h10 >> k);
      frame(bd, bs, be, bo, 8'h01);
      chk(rq, 9'h000);
      @(posedge clk);
      {ck_m, ck_u, ck_s, ck_e, ck_o} <= 5'h00;
      frame(bd, bs, be, bo, 8'h01);
      chk(rq, 9'h001);
      look(8);
    end
    @(posedge clk);
    en_prio <= 1'b0;
    frame(sta, 48'h0, `PFC_ETYPE_PAUSE, `PFC_OP_PRIO, 8'h01);
    chk(rq, 9'h000);
    @(posedge clk);
    en_prio <= 1'b1;
    rxen <= 9'h1df;
    slow <= 1'b0;
    frame(sta, 48'h0, `PFC_ETYPE_PAUSE, `PFC_OP_PRIO, 8'h20);
    chk(rv, 9'h000);
    @(posedge clk);
    rxen <= 9'h1ff;
    look(1);
    chk(rq, 9'h020);
    // every priority at once; the ack of channel 5 meets this frame, so the set must win
    frame(sta, 48'h0, `PFC_ETYPE_PAUSE, `PFC_OP_PRIO, 8'hff);
    chk(rv, 9'h0ff);
    chk(rq, 9'h0ff);
    for (k = 0; k < 8; k++) chk(rxq[k], tv[16*k +: 16]);
    @(posedge clk);
    txr <= 9'h008;
    wait_tx(4'h3, 1'b0, txq[3]);
    @(posedge clk);
    slow <= 1'b1;
    wait_tx(4'h3, 1'b0, txq[3]);
    @(posedge clk);
    {txr, ivl, slow} <= '0;
    look(16);
    @(posedge clk);
    txr <= 9'h100;
    wait_tx(4'h8, 1'b1, txq[8]);
    look(16);
    @(posedge clk);
    txr <= 9'h004;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      seen = seen | tvld;
    end
    chk(seen, 1'b0);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
